// ===== hw/cpm_prog_model.sv
// programmer-visible core state, operand writes and address modes
// assumes decode drives the core-side strobes on clk_sys
`timescale 1ns/1ps
module cpm_prog_model
  import cpm_pkg::*;
#(
  parameter logic [31:0] SSP_RST = 32'h0000_0000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire cpm_pkg::cpm_opnd_t wr_opnd,
  input wire logic [31:0] wr_data,
  input wire logic flag_v,
  input wire logic flag_c,
  input wire logic flag_x,
  input wire logic flag_x_upd,
  input wire logic ssp_wr,
  input wire logic [31:0] ssp_wdata,
  input wire logic psw_wr,
  input wire logic psw_full,
  input wire logic [15:0] psw_wdata,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  input wire logic [3:0] rd_sel,
  input wire logic ea_req,
  input wire cpm_pkg::cpm_ea_mode_t ea_mode,
  input wire logic [2:0] ea_reg,
  input wire cpm_pkg::cpm_opnd_t ea_opnd,
  input wire logic [31:0] ea_ext,
  input wire logic [3:0] idx_sel,
  input wire logic idx_long,
  output logic [31:0] rd_data,
  output logic [31:0] ea_addr,
  output logic ea_valid,
  output logic [31:0] program_counter,
  output logic [15:0] processor_status_word,
  output logic priv_violation,
  output logic size_error,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cpm_pkg::*;

  typedef struct packed {
    logic [7:0][31:0] opr;
    logic [6:0][31:0] ptr;
    logic [31:0] user_stack_ptr;
    logic [31:0] privileged_stack_ptr;
    logic [31:0] pc;
    logic [15:0] psw;
    logic freeze;
    logic pviol;
    logic serr;
    logic [31:0] ea_addr;
    logic ea_valid;
    logic [31:0] rd_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpm_state_t;

  cpm_state_t st_r;
  cpm_state_t st_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge_sized(input logic [31:0] old,
      input logic [31:0] val, input cpm_opnd_t op);
    case (op)
      OP_LONG: merge_sized = val;
      OP_WORD: merge_sized = {old[31:16], val[15:0]};
      default: merge_sized = {old[31:8], val[7:0]};
    endcase
  endfunction : merge_sized

  function automatic logic [31:0] reg_value(input cpm_state_t s,
      input logic [3:0] sel);
    if (!sel[3]) begin
      reg_value = s.opr[sel[2:0]];
    end else if (sel[2:0] != 3'h7) begin
      reg_value = s.ptr[sel[2:0]];
    end else begin
      reg_value = s.psw[SR_S] ? s.privileged_stack_ptr : s.user_stack_ptr;
    end
  endfunction : reg_value

  // ---------------------------------------------------------------
  // flags and address arithmetic
  // ---------------------------------------------------------------
  logic res_n;
  logic res_z;
  logic [31:0] idx_raw;
  logic [31:0] idx_val;
  logic [31:0] ea_base;
  logic [31:0] ea_step;
  logic [31:0] ea_addr_c;
  logic [31:0] ea_base_nxt;
  logic ea_base_upd;
  logic [3:0] ea_sel;
  logic ptr_ok;

  cpm_flag_gen u_flag (
    .result(wr_data),
    .opnd(wr_opnd),
    .flag_n(res_n),
    .flag_z(res_z)
  );

  assign idx_raw = reg_value(st_r, idx_sel);
  assign idx_val = idx_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]};
  assign ea_sel = {1'b1, ea_reg};
  assign ea_base = reg_value(st_r, ea_sel);
  // byte steps on the stack pointer keep it word aligned
  assign ea_step = (ea_opnd == OP_LONG) ? 32'h0000_0004 :
                   (ea_opnd == OP_WORD || ea_reg == SEL_SP[2:0]) ?
                   32'h0000_0002 : 32'h0000_0001;

  cpm_ea_unit u_ea (
    .mode(ea_mode),
    .base(ea_base),
    .pc(st_r.pc),
    .ext(ea_ext),
    .idx_val(idx_val),
    .step(ea_step),
    .addr(ea_addr_c),
    .base_nxt(ea_base_nxt),
    .base_upd(ea_base_upd)
  );

  assign ptr_ok = (wr_opnd == OP_WORD) || (wr_opnd == OP_LONG);

  // ---------------------------------------------------------------
  // register window decode
  // ---------------------------------------------------------------
  logic aw_go;
  logic ar_go;
  logic [31:0] win_data;
  logic win_hit;

  assign aw_go = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
  assign ar_go = s_axi_arvalid && !st_r.rvalid;

  always_comb begin
    win_data = 32'h0000_0000;
    win_hit = 1'b1;
    if (s_axi_araddr < OFS_PTR) begin
      win_data = st_r.opr[s_axi_araddr[4:2]];
    end else if (s_axi_araddr < OFS_USP) begin
      win_data = st_r.ptr[3'(s_axi_araddr[4:2])];
    end else begin
      case (s_axi_araddr)
        OFS_USP: win_data = st_r.user_stack_ptr;
        OFS_SSP: win_data = st_r.privileged_stack_ptr;
        OFS_PC: win_data = st_r.pc;
        OFS_PSW: win_data = {16'h0000, st_r.psw};
        OFS_CTRL: win_data = {31'h0000_0000, st_r.freeze};
        default: win_hit = 1'b0;
      endcase
    end
    if (s_axi_araddr[1:0] != 2'b00) begin
      win_hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pviol = 1'b0;
    st_nxt.serr = 1'b0;
    st_nxt.ea_valid = 1'b0;
    st_nxt.rd_data = reg_value(st_r, rd_sel);
    if (ea_req && !st_r.freeze) begin
      st_nxt.ea_addr = ea_addr_c;
      st_nxt.ea_valid = 1'b1;
      if (ea_base_upd) begin
        if (ea_reg != SEL_SP[2:0]) begin
          st_nxt.ptr[ea_reg] = ea_base_nxt;
        end else if (st_r.psw[SR_S]) begin
          st_nxt.privileged_stack_ptr = ea_base_nxt;
        end else begin
          st_nxt.user_stack_ptr = ea_base_nxt;
        end
      end
    end
    if (wr_en && !st_r.freeze) begin
      if (!wr_sel[3]) begin
        st_nxt.opr[wr_sel[2:0]] =
          merge_sized(st_r.opr[wr_sel[2:0]], wr_data, wr_opnd);
        st_nxt.psw[SR_N] = res_n;
        st_nxt.psw[SR_Z] = res_z;
        st_nxt.psw[SR_V] = flag_v;
        st_nxt.psw[SR_C] = flag_c;
        if (flag_x_upd) begin
          st_nxt.psw[SR_X] = flag_x;
        end
      end else if (!ptr_ok) begin
        st_nxt.serr = 1'b1;
      end else begin
        // word writes to pointers fill all 32 bits by sign
        if (wr_sel[2:0] != SEL_SP[2:0]) begin
          st_nxt.ptr[wr_sel[2:0]] = (wr_opnd == OP_LONG) ? wr_data :
            {{16{wr_data[15]}}, wr_data[15:0]};
        end else if (st_r.psw[SR_S]) begin
          st_nxt.privileged_stack_ptr = (wr_opnd == OP_LONG) ? wr_data :
            {{16{wr_data[15]}}, wr_data[15:0]};
        end else begin
          st_nxt.user_stack_ptr = (wr_opnd == OP_LONG) ? wr_data :
            {{16{wr_data[15]}}, wr_data[15:0]};
        end
      end
    end
    if (ssp_wr && !st_r.freeze) begin
      if (st_r.psw[SR_S]) begin
        st_nxt.privileged_stack_ptr = ssp_wdata;
      end else begin
        st_nxt.pviol = 1'b1;
      end
    end
    if (psw_wr && !st_r.freeze) begin
      if (!psw_full) begin
        st_nxt.psw[7:0] = psw_wdata[7:0] & SR_IMPL[7:0];
      end else if (st_r.psw[SR_S]) begin
        st_nxt.psw = psw_wdata & SR_IMPL;
      end else begin
        st_nxt.pviol = 1'b1;
      end
    end
    if (pc_load && !st_r.freeze) begin
      st_nxt.pc = pc_value;
    end
    if (aw_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (s_axi_awaddr == OFS_CTRL) begin
        if (s_axi_wstrb[0]) begin
          st_nxt.freeze = s_axi_wdata[0];
        end
      end else if (s_axi_awaddr > OFS_CTRL ||
                   s_axi_awaddr[1:0] != 2'b00) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (ar_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = win_data;
      st_nxt.rresp = win_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.user_stack_ptr <= USP_RST;
      st_r.privileged_stack_ptr <= SSP_RST;
      st_r.pc <= PC_RST;
      st_r.psw <= SR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data = st_r.rd_data;
  assign ea_addr = st_r.ea_addr;
  assign ea_valid = st_r.ea_valid;
  assign program_counter = st_r.pc;
  assign processor_status_word = st_r.psw;
  assign priv_violation = st_r.pviol;
  assign size_error = st_r.serr;
  assign s_axi_awready = aw_go;
  assign s_axi_wready = aw_go;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = ar_go;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic opr_wr_c;
  logic ptr_wr_c;
  assign opr_wr_c = wr_en && !wr_sel[3] && !st_r.freeze && !psw_wr;
  assign ptr_wr_c = wr_en && wr_sel[3] && !st_r.freeze;

  sequence s_pc_disp_req;
    ea_req && !st_r.freeze && ea_mode == EA_PC_DISP16;
  endsequence
  sequence s_postinc_req;
    ea_req && !st_r.freeze && ea_mode == EA_POSTINC &&
      ea_reg != SEL_SP[2:0] && !ptr_wr_c;
  endsequence

  chk_byte_merge_upper: assert property (
    opr_wr_c && wr_opnd == OP_BYTE |=>
      st_r.opr[$past(wr_sel[2:0])][31:8] ==
      $past(st_r.opr[wr_sel[2:0]][31:8]))
    else $error("byte write disturbed upper bits");
  chk_flags_follow_result: assert property (
    opr_wr_c |=> st_r.psw[SR_Z] == $past(res_z) &&
      st_r.psw[SR_C] == $past(flag_c))
    else $error("flags not updated from result");
  chk_ptr_keeps_flags: assert property (
    ptr_wr_c && !psw_wr |=> $stable(st_r.psw[4:0]))
    else $error("pointer write changed flags");
  chk_ptr_byte_refused: assert property (
    ptr_wr_c && !ptr_ok && !ea_req |=> size_error && $stable(st_r.ptr))
    else $error("byte write to pointer accepted");
  chk_user_psw_guard: assert property (
    psw_wr && psw_full && !st_r.freeze && !st_r.psw[SR_S] |=>
      priv_violation && $stable(st_r.psw[15:8]))
    else $error("user write reached upper status byte");
  chk_ssp_user_guard: assert property (
    ssp_wr && !st_r.psw[SR_S] && !(ea_req && ea_reg == SEL_SP[2:0]) &&
      !(ptr_wr_c && wr_sel == 4'hf) |=> $stable(st_r.privileged_stack_ptr))
    else $error("privileged stack pointer written at user level");
  chk_pc_loads_value: assert property (
    pc_load && !st_r.freeze |=> program_counter == $past(pc_value))
    else $error("program counter not loaded");
  chk_pc_disp_addr: assert property (
    s_pc_disp_req |=> ea_valid && ea_addr == $past(st_r.pc) +
      {{16{$past(ea_ext[15])}}, $past(ea_ext[15:0])})
    else $error("pc relative address wrong");
  chk_postinc_step: assert property (
    s_postinc_req ##1 1'b1 |->
      st_r.ptr[$past(ea_reg)] == $past(ea_base) + $past(ea_step) &&
      ea_addr == $past(ea_base))
    else $error("post-increment update wrong");
endmodule : cpm_prog_model

// ===== hw/cpm_pkg.sv
// constants and types for the core programming model
// assumes one system clock and an axi4-lite register window
package cpm_pkg;
  // ---------------------------------------------------------------
  // operand types and address modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {OP_BIT, OP_BCD, OP_BYTE, OP_WORD, OP_LONG}
    cpm_opnd_t;
  typedef enum logic [3:0] {
    EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP16,
    EA_IDX8, EA_ABS_W, EA_ABS_L, EA_PC_DISP16, EA_PC_IDX8, EA_IMM,
    EA_IMPLIED
  } cpm_ea_mode_t;
  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int SR_C = 0;
  localparam int SR_V = 1;
  localparam int SR_Z = 2;
  localparam int SR_N = 3;
  localparam int SR_X = 4;
  localparam int SR_MASK_LO = 8;
  localparam int SR_S = 13;
  localparam int SR_T = 15;
  localparam logic [15:0] SR_RST = 16'h2700;
  localparam logic [15:0] SR_IMPL = 16'ha71f;
  localparam logic [31:0] USP_RST = 32'h0000_0000;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  // ---------------------------------------------------------------
  // register window byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OPR = 8'h00;
  localparam logic [7:0] OFS_PTR = 8'h20;
  localparam logic [7:0] OFS_USP = 8'h3c;
  localparam logic [7:0] OFS_SSP = 8'h40;
  localparam logic [7:0] OFS_PC = 8'h44;
  localparam logic [7:0] OFS_PSW = 8'h48;
  localparam logic [7:0] OFS_CTRL = 8'h4c;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] SEL_SP = 4'h7;
endpackage : cpm_pkg

// ===== hw/cpm_flag_gen.sv
// negative and zero flags of a sized result
// assumes the caller supplies the operand type of the result
`timescale 1ns/1ps
module cpm_flag_gen
  import cpm_pkg::*;
(
  input wire logic [31:0] result,
  input wire cpm_pkg::cpm_opnd_t opnd,
  output logic flag_n,
  output logic flag_z
);
  always_comb begin
    case (opnd)
      OP_LONG: begin
        flag_n = result[31];
        flag_z = (result == 32'h0000_0000);
      end
      OP_WORD: begin
        flag_n = result[15];
        flag_z = (result[15:0] == 16'h0000);
      end
      default: begin
        flag_n = result[7];
        flag_z = (result[7:0] == 8'h00);
      end
    endcase
  end
endmodule : cpm_flag_gen

// ===== hw/cpm_ea_unit.sv
// effective address arithmetic for all address mode families
// assumes extension words already fetched and sign handling by mode
`timescale 1ns/1ps
module cpm_ea_unit
  import cpm_pkg::*;
(
  input wire cpm_pkg::cpm_ea_mode_t mode,
  input wire logic [31:0] base,
  input wire logic [31:0] pc,
  input wire logic [31:0] ext,
  input wire logic [31:0] idx_val,
  input wire logic [31:0] step,
  output logic [31:0] addr,
  output logic [31:0] base_nxt,
  output logic base_upd
);
  logic [31:0] d16;
  logic [31:0] d8;
  assign d16 = {{16{ext[15]}}, ext[15:0]};
  assign d8 = {{24{ext[7]}}, ext[7:0]};
  always_comb begin
    addr = base;
    base_nxt = base;
    base_upd = 1'b0;
    case (mode)
      EA_POSTINC: begin
        base_nxt = base + step;
        base_upd = 1'b1;
      end
      EA_PREDEC: begin
        addr = base - step;
        base_nxt = base - step;
        base_upd = 1'b1;
      end
      EA_DISP16: addr = base + d16;
      EA_IDX8: addr = base + d8 + idx_val;
      EA_ABS_W: addr = d16;
      EA_ABS_L: addr = ext;
      EA_PC_DISP16: addr = pc + d16;
      EA_PC_IDX8: addr = pc + d8 + idx_val;
      EA_IMM: addr = ext;
      default: addr = base;
    endcase
  end
endmodule : cpm_ea_unit

// ===== testbench/cpu_programming_model_bench.sv
// self-checking bench for the core programming model
// assumes cpm_pkg and cpm_prog_model compiled first, ssp reset value 0
`timescale 1ns/1ps
module cpu_programming_model_bench;
  import cpm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, wr_en, flag_v, flag_c, flag_x, flag_x_upd, ssp_wr, psw_wr;
  logic psw_full, pc_load, ea_req, idx_long, ea_valid;
  logic priv_violation, size_error;
  logic [3:0] wr_sel, rd_sel, idx_sel, s_axi_wstrb;
  logic [2:0] ea_reg;
  cpm_opnd_t wr_opnd, ea_opnd;
  cpm_ea_mode_t ea_mode;
  logic [31:0] wr_data, ssp_wdata, pc_value, ea_ext, rd_data, ea_addr;
  logic [31:0] program_counter, s_axi_wdata, s_axi_rdata;
  logic [15:0] psw_wdata, processor_status_word;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] m_opr [8];
  logic [31:0] m_ptr [7];
  logic [31:0] m_usp, m_ssp, m_pc;
  logic [15:0] m_psw;
  logic m_frz;
  logic [33:0] xr;
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  logic [31:0] eq [$];
  int fail_count, n_checks, n_pv, n_se, e_pv, e_se;

  cpm_prog_model dut (
    .clk_sys, .rst_n, .wr_en, .wr_sel, .wr_opnd, .wr_data, .flag_v,
    .flag_c, .flag_x, .flag_x_upd, .ssp_wr, .ssp_wdata, .psw_wr,
    .psw_full, .psw_wdata, .pc_load, .pc_value, .rd_sel, .ea_req,
    .ea_mode, .ea_reg, .ea_opnd, .ea_ext, .idx_sel, .idx_long,
    .rd_data, .ea_addr, .ea_valid, .program_counter,
    .processor_status_word, .priv_violation, .size_error,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );

  always #20 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // reference state
  // ---------------------------------------------------------------
  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : sx16

  function automatic logic [31:0] m_reg(input logic [3:0] s);
    if (s < 4'd8) return m_opr[s[2:0]];
    if (s < 4'd15) return m_ptr[s - 4'd8];
    return m_psw[SR_S] ? m_ssp : m_usp;
  endfunction : m_reg

  task automatic m_set(input logic [3:0] s, input logic [31:0] v);
    if (s < 4'd8) m_opr[s[2:0]] = v;
    else if (s < 4'd15) m_ptr[s - 4'd8] = v;
    else if (m_psw[SR_S]) m_ssp = v;
    else m_usp = v;
  endtask : m_set

  function automatic logic [31:0] m_at(input logic [7:0] a);
    if (a < OFS_PTR) return m_opr[a[4:2]];
    if (a < OFS_USP) return m_ptr[(a - OFS_PTR) >> 2];
    case (a)
      OFS_USP: return m_usp;
      OFS_SSP: return m_ssp;
      OFS_PC: return m_pc;
      OFS_PSW: return {16'h0000, m_psw};
      default: return {31'h0, m_frz};
    endcase
  endfunction : m_at

  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    xr = 34'(rq.size() + bq.size() + eq.size());
    check("pending results", xr, 34'h0);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      xr = rq.size() ? rq.pop_front() : 'x;
      check("read", {s_axi_rresp, s_axi_rdata}, xr);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      xr = bq.size() ? 34'(bq.pop_front()) : 'x;
      check("bresp", 34'(s_axi_bresp), xr);
    end
    if (ea_valid === 1'b1) begin
      xr = eq.size() ? 34'(eq.pop_front()) : 'x;
      check("ea_addr", 34'(ea_addr), xr);
    end
    if (priv_violation === 1'b1) n_pv++;
    if (size_error === 1'b1) n_se++;
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic strobe_done();
    @(posedge clk_sys);
    {wr_en, ssp_wr, psw_wr, pc_load, ea_req} <= '0;
    @(posedge clk_sys);
  endtask : strobe_done

  task automatic opr_wr(input logic [3:0] s, input cpm_opnd_t op,
                        input logic [31:0] d);
    logic [31:0] m;
    logic [3:0] f;
    m = op == OP_LONG ? 32'hffffffff : 32'h000000ff;
    if (op == OP_WORD) m = 32'h0000ffff;
    f = 4'($urandom);
    {flag_x_upd, flag_x, flag_v, flag_c} <= f;
    {wr_en, wr_sel, wr_data} <= {1'b1, s, d};
    wr_opnd <= op;
    if (!m_frz && s < 4'd8) begin
      m_set(s, (m_reg(s) & ~m) | (d & m));
      m_psw[4] = f[3] ? f[2] : m_psw[SR_X];
      m_psw[3:0] = {|(d & m & ~(m >> 1)), (d & m) == 0, f[1:0]};
    end else if (!m_frz) begin
      if (op == OP_LONG) m_set(s, d);
      else if (op == OP_WORD) m_set(s, sx16(d[15:0]));
      else e_se++;
    end
    strobe_done();
  endtask : opr_wr

  task automatic ctl_wr(input int k, input logic [31:0] d, input logic fl);
    {ssp_wdata, pc_value, psw_wdata, psw_full} <= {d, d, d[15:0], fl};
    if (k == 0) ssp_wr <= 1'b1;
    else if (k == 1) psw_wr <= 1'b1;
    else pc_load <= 1'b1;
    if (!m_frz) begin
      if (k == 2) m_pc = d;
      else if (k == 1 && !fl) m_psw[7:0] = d[7:0] & SR_IMPL[7:0];
      else if (!m_psw[SR_S]) e_pv++;
      else if (k == 1) m_psw = d[15:0] & SR_IMPL;
      else m_ssp = d;
    end
    strobe_done();
  endtask : ctl_wr

  task automatic ea_calc(input cpm_ea_mode_t md, input logic [2:0] r,
                         input cpm_opnd_t op, input logic [31:0] x,
                         input logic [3:0] is, input logic il);
    logic [31:0] b, t, ix, st, a, d8;
    b = m_reg({1'b1, r});
    t = m_reg(is);
    ix = il ? t : sx16(t[15:0]);
    st = op == OP_LONG ? 4 : op == OP_WORD ? 2 : r == 3'd7 ? 2 : 1;
    d8 = {{24{x[7]}}, x[7:0]};
    case (md)
      EA_PREDEC: a = b - st;
      EA_DISP16: a = b + sx16(x[15:0]);
      EA_IDX8: a = b + d8 + ix;
      EA_ABS_W: a = sx16(x[15:0]);
      EA_ABS_L, EA_IMM: a = x;
      EA_PC_DISP16: a = m_pc + sx16(x[15:0]);
      EA_PC_IDX8: a = m_pc + d8 + ix;
      default: a = b;
    endcase
    {ea_req, ea_reg, ea_ext, idx_sel, idx_long} <= {1'b1, r, x, is, il};
    ea_mode <= md;
    ea_opnd <= op;
    if (!m_frz) begin
      if (md == EA_POSTINC) m_set({1'b1, r}, b + st);
      if (md == EA_PREDEC) m_set({1'b1, r}, a);
      eq.push_back(a);
    end
    strobe_done();
  endtask : ea_calc

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    int t;
    t = 0;
    rq.push_back(exp);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1 && t++ < 99);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1 && t++ < 99);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_rd

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] exp);
    int t;
    t = 0;
    bq.push_back(exp);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do @(posedge clk_sys);
    while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1) && t++ < 99);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1 && t++ < 99);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_wr

  task automatic dump();
    for (int s = 0; s < 16; s++) begin
      rd_sel <= 4'(s);
      repeat (2) @(posedge clk_sys);
      check("rd_data", 34'(rd_data), 34'(m_reg(4'(s))));
    end
    for (int a = 0; a <= 'h4c; a += 4) axi_rd(8'(a), {RESP_OKAY, m_at(8'(a))});
    check("pc port", 34'(program_counter), 34'(m_pc));
    check("psw port", 34'(processor_status_word), 34'(m_psw));
  endtask : dump

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hd608d4aa));
    {rst_n, wr_en, ssp_wr, psw_wr, pc_load, ea_req, psw_full} <= '0;
    {flag_v, flag_c, flag_x, flag_x_upd, idx_long, ea_reg} <= '0;
    {wr_sel, rd_sel, idx_sel, wr_data, ssp_wdata, psw_wdata} <= '0;
    {pc_value, ea_ext, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} <= 6'h0f;
    wr_opnd <= OP_LONG;
    ea_opnd <= OP_LONG;
    ea_mode <= EA_DREG;
    foreach (m_opr[i]) m_opr[i] = '0;
    foreach (m_ptr[i]) m_ptr[i] = '0;
    {m_usp, m_ssp, m_pc, m_psw, m_frz} = {USP_RST, 32'h0, PC_RST, SR_RST, 1'b0};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    dump();
    for (int i = 0; i < 8; i++) opr_wr(4'(i), OP_LONG, $urandom);
    for (int i = 0; i < 20; i++) opr_wr(4'(i), cpm_opnd_t'(i % 5), $urandom);
    opr_wr(4'd1, OP_BYTE, 32'hffffff00);
    opr_wr(4'd2, OP_WORD, 32'h00018000);
    dump();
    for (int i = 8; i < 16; i++) opr_wr(4'(i), cpm_opnd_t'(i % 2 + 3), $urandom);
    for (int i = 0; i < 3; i++) opr_wr(4'(9 + i), cpm_opnd_t'(i), $urandom);
    dump();
    check("size_error count", 34'(n_se), 34'(e_se));
    ctl_wr(2, $urandom, 1'b0);
    for (int i = 0; i < 39; i++)
      ea_calc(cpm_ea_mode_t'(i % 13), 3'($urandom), cpm_opnd_t'(i % 5),
              $urandom, 4'($urandom), 1'($urandom));
    ea_calc(EA_POSTINC, 3'd7, OP_BYTE, 0, 4'd0, 1'b1);
    ea_calc(EA_PREDEC, 3'd7, OP_BIT, 0, 4'd15, 1'b0);
    dump();
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    m_frz = 1'b1;
    opr_wr(4'd0, OP_LONG, 32'h5a5a5a5a);
    ea_calc(EA_POSTINC, 3'd0, OP_LONG, 0, 4'd0, 1'b1);
    ctl_wr(2, 32'h1234, 1'b0);
    dump();
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    m_frz = 1'b0;
    axi_wr(OFS_OPR, 32'hdeadbeef, RESP_OKAY);
    axi_wr(8'h50, 32'h1, RESP_SLVERR);
    axi_rd(8'h50, {RESP_SLVERR, 32'h0});
    axi_rd(8'h4a, {RESP_SLVERR, 32'h0});
    ctl_wr(1, 32'hffff, 1'b1);
    ctl_wr(1, 32'h0000, 1'b0);
    ctl_wr(0, $urandom, 1'b0);
    dump();
    ctl_wr(1, 32'h0000, 1'b1);
    ctl_wr(0, $urandom, 1'b0);
    ctl_wr(1, 32'h2700, 1'b1);
    ctl_wr(1, 32'h00ff, 1'b0);
    opr_wr(4'd15, OP_LONG, $urandom);
    ea_calc(EA_PREDEC, 3'd7, OP_WORD, 0, 4'd0, 1'b1);
    dump();
    check("priv_violation count", 34'(n_pv), 34'(e_pv));
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
endmodule : cpu_programming_model_bench
